// File: core/ffp_device.sv
`timescale 1ns/1ps
module ffp_device #(
  parameter logic [15:0] TMO_CYC = 16'(ffp_pkg::SOFT_TMO_CYC)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register link
  ffp_if.dev lk,
  // Pins
  input wire logic bus_width_strap,
  input wire logic phy_clk_run,
  // MAC transmit side
  output logic mac_tx_valid,
  output logic [31:0] mac_tx_data,
  output logic mac_tx_last,
  input wire logic mac_tx_ready,
  // MAC receive side
  input wire logic mac_rx_valid,
  input wire logic [31:0] mac_rx_data,
  input wire logic mac_rx_last,
  // MAC control register reset
  output logic mac_csr_reset
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic p1;
    logic p2;
    logic seen;
    logic [3:0] kb;
    logic rst_busy;
    logic rst_tmo;
    logic [15:0] cnt;
    logic tx_err;
    logic rx_err;
    logic [15:0] drop;
    logic drop_on;
    logic skip;
    logic [11:0] tw, tr, tc, rw, rr, rc;
    logic [8:0] sw, sr;
    logic [9:0] sc;
    logic [4:0] qw, qr;
    logic [5:0] qc;
    logic ov;
    logic ol;
    logic [31:0] od;
    logic mrst;
    logic [31:0] rdata;
  } ffp_dev_t;

  ffp_dev_t q, n;
  logic [32:0] mem_q [4096];
  logic [32:0] stg_t [512];
  logic [32:0] stg_r [32];
  logic mw;
  logic [11:0] ma;
  logic [32:0] md;
  logic tmv;
  logic rin;

  //////////////////////////////////////////////////////////////////////////////
  // Packet memory and staging buffers
  always_ff @(posedge mclk) begin
    if (mw) begin
      mem_q[ma] <= md;
    end
    if (tmv) begin
      stg_t[q.sw] <= mem_q[q.tr];
    end
    if (rin) begin
      stg_r[q.qw] <= {mac_rx_last, mac_rx_data};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [11:0] txw, rxw, rxb;
    logic [32:0] head;
    logic [31:0] v;
    logic wr, rd, txa, push, pop, full, rmv, oload;
    txw = ffp_pkg::f_txd_words(q.kb);
    rxw = ffp_pkg::f_rxd_words(q.kb);
    rxb = {ffp_pkg::f_kb(q.kb), 8'h00};
    head = mem_q[rxb + q.rr];
    v = '0;
    n = q;
    n.mrst = 1'b0;
    // Bus decode; writes wait for a first read
    rd = lk.cs & !lk.we;
    wr = lk.cs & lk.we & q.seen & !q.rst_busy;
    if (rd) begin
      n.seen = 1'b1;
    end
    txa = (lk.addr == ffp_pkg::TX_DATA_OFS) |
          (lk.addr == ffp_pkg::TX_LAST_OFS);
    push = wr & txa & (q.tc != txw);
    pop = (q.skip | (rd & lk.addr == ffp_pkg::RX_DATA_OFS)) & (q.rc != 0);
    full = q.rc >= rxw - ffp_pkg::RXD_GAP;
    tmv = (q.tc != 0) & (q.sc != ffp_pkg::STG_TX_WORDS);
    rmv = (q.qc != 0) & !full & !push;
    oload = (q.sc != 0) & (!q.ov | mac_tx_ready);
    rin = mac_rx_valid & !q.drop_on & (q.qc != ffp_pkg::STG_RX_WORDS);
    // Packet memory write port
    mw = push | rmv;
    ma = push ? q.tw : rxb + q.rw;
    md = push ? {lk.addr == ffp_pkg::TX_LAST_OFS, lk.wdata} : stg_r[q.qr];
    // Transmit data FIFO
    if (push) begin
      n.tw = ffp_pkg::f_inc(q.tw, txw);
    end
    if (tmv) begin
      n.tr = ffp_pkg::f_inc(q.tr, txw);
      n.sw = q.sw + 9'h001;
    end
    n.tc = q.tc + 12'(push) - 12'(tmv);
    if (wr & txa & (q.tc == txw)) begin
      n.tx_err = 1'b1;
    end
    // Transmit staging to MAC
    if (oload) begin
      n.ov = 1'b1;
      {n.ol, n.od} = stg_t[q.sr];
      n.sr = q.sr + 9'h001;
    end else if (mac_tx_ready) begin
      n.ov = 1'b0;
    end
    n.sc = q.sc + 10'(tmv) - 10'(oload);
    // Receive staging from MAC, frame drop on overrun
    if (rin) begin
      n.qw = q.qw + 5'h01;
    end else if (mac_rx_valid) begin
      n.drop_on = !mac_rx_last | full;
      if (mac_rx_last) begin
        n.drop = q.drop + 16'h0001;
      end
    end
    if (rmv) begin
      n.qr = q.qr + 5'h01;
      n.rw = ffp_pkg::f_inc(q.rw, rxw);
    end
    n.qc = q.qc + 6'(rin) - 6'(rmv);
    // Receive data FIFO drain and frame skip
    if (pop) begin
      n.rr = ffp_pkg::f_inc(q.rr, rxw);
      if (q.skip & head[32]) begin
        n.skip = 1'b0;
      end
    end
    n.rc = q.rc + 12'(rmv) - 12'(pop);
    if (rd & lk.addr == ffp_pkg::RX_DATA_OFS & q.rc == 0 & !q.skip) begin
      n.rx_err = 1'b1;
    end
    // Register reads; staging levels stay out of view
    if (rd) begin
      case (lk.addr)
        ffp_pkg::RX_DATA_OFS: v = head[31:0];
        ffp_pkg::STATUS_OFS: begin
          v[ffp_pkg::DROP_LSB +: 16] = q.drop;
          v[1:0] = {q.rx_err, q.tx_err};
        end
        ffp_pkg::LEVEL_OFS: begin
          v[11:0] = q.rc;
          v[ffp_pkg::TXFREE_LSB +: 12] = txw - q.tc;
        end
        ffp_pkg::HW_SETUP_OFS: begin
          v[ffp_pkg::KB_LSB +: 4] = q.kb;
          v[ffp_pkg::STRAP_BIT] = q.s2;
          v[ffp_pkg::TO_BIT] = q.rst_tmo;
          v[ffp_pkg::SOFT_RST_BIT] = q.rst_busy;
        end
        ffp_pkg::RX_PATH_OFS: v[ffp_pkg::SKIP_BIT] = q.skip;
        default: v = '0;
      endcase
      n.rdata = v;
    end
    // Register writes
    if (wr & lk.addr == ffp_pkg::RX_PATH_OFS &
        lk.wdata[ffp_pkg::SKIP_BIT]) begin
      n.skip = 1'b1;
    end
    if (wr & lk.addr == ffp_pkg::HW_SETUP_OFS) begin
      n.kb = lk.wdata[ffp_pkg::KB_LSB +: 4];
      if (n.kb != q.kb) begin
        n.tw = '0;
        n.tr = '0;
        n.tc = '0;
        n.rw = '0;
        n.rr = '0;
        n.rc = '0;
      end
      if (lk.wdata[ffp_pkg::SOFT_RST_BIT]) begin
        n.rst_busy = 1'b1;
        n.cnt = '0;
      end
    end
    // Soft reset: finish with PHY clocks, else time out
    if (q.rst_busy) begin
      if (q.p2) begin
        n = '0;
        n.kb = ffp_pkg::KB_RST;
        n.mrst = 1'b1;
        n.s1 = q.s1;
        n.s2 = q.s2;
        n.p1 = q.p1;
        n.p2 = q.p2;
      end else if (q.cnt == TMO_CYC - 16'h0001) begin
        n.rst_busy = 1'b0;
        n.rst_tmo = 1'b1;
      end else begin
        n.cnt = q.cnt + 16'h0001;
      end
    end
    // Pin synchronisers
    n.s1 = bus_width_strap;
    n.s2 = q.s1;
    n.p1 = phy_clk_run;
    n.p2 = q.p1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.kb <= ffp_pkg::KB_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs
  assign lk.rdata = q.rdata;
  assign mac_tx_valid = q.ov;
  assign mac_tx_data = q.od;
  assign mac_tx_last = q.ol;
  assign mac_csr_reset = q.mrst;
endmodule : ffp_device

// File: core/ffp_host.sv
`timescale 1ns/1ps
module ffp_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // PHY awake pin
  input wire logic phy_ready,
  // Register link
  ffp_if.host lk
);
  typedef enum logic [2:0] {
    S_IDLE, S_DUM, S_ACC, S_CAP, S_PL1, S_PL2, S_DONE
  } ffp_hst_st_t;

  typedef struct packed {
    ffp_hst_st_t st;
    logic r1;
    logic r2;
    logic need_rd;
    logic pend;
    logic stopped;
    logic refused;
    logic lwe;
    logic [7:0] la;
    logic [31:0] lwd;
    logic [31:0] rdat;
  } ffp_hst_t;

  ffp_hst_t q, n;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [3:0] kbw;
    logic bad;
    kbw = avs_writedata[ffp_pkg::KB_LSB +: 4];
    bad = !q.stopped | kbw < ffp_pkg::KB_MIN | kbw > ffp_pkg::KB_MAX |
          (avs_writedata[ffp_pkg::SOFT_RST_BIT] & !q.r2);
    n = q;
    n.r1 = phy_ready;
    n.r2 = q.r1;
    case (q.st)
      S_IDLE: begin
        if (avs_read | avs_write) begin
          n.la = avs_address;
          n.lwe = avs_write;
          n.lwd = avs_writedata;
          n.st = S_ACC;
          if (avs_address >= ffp_pkg::HOST_CTRL_OFS) begin
            // Own registers answer locally
            n.st = S_DONE;
            if (avs_read) begin
              n.rdat = (avs_address == ffp_pkg::HOST_CTRL_OFS) ?
                       {31'h0, q.stopped} : {30'h0, q.pend, q.refused};
            end else if (avs_address == ffp_pkg::HOST_CTRL_OFS) begin
              n.stopped = avs_writedata[0];
            end else if (avs_writedata[0]) begin
              n.refused = 1'b0;
            end
          end else if (avs_write & avs_address == ffp_pkg::HW_SETUP_OFS &
                       bad) begin
            n.refused = 1'b1;
            n.st = S_DONE;
          end else if (avs_read & q.pend &
                       avs_address == ffp_pkg::RX_DATA_OFS) begin
            n.la = ffp_pkg::RX_PATH_OFS;
            n.lwe = 1'b0;
            n.st = S_PL1;
          end else if (avs_write & q.need_rd) begin
            n.la = ffp_pkg::HW_SETUP_OFS;
            n.lwe = 1'b0;
            n.st = S_DUM;
          end
        end
      end
      S_DUM: begin
        n.need_rd = 1'b0;
        n.la = avs_address;
        n.lwe = 1'b1;
        n.st = S_ACC;
      end
      S_ACC: begin
        if (q.lwe & q.la == ffp_pkg::RX_PATH_OFS &
            q.lwd[ffp_pkg::SKIP_BIT]) begin
          n.pend = 1'b1;
        end
        if (q.lwe & q.la == ffp_pkg::HW_SETUP_OFS &
            q.lwd[ffp_pkg::SOFT_RST_BIT]) begin
          n.need_rd = 1'b1;
        end
        n.st = S_CAP;
      end
      S_CAP: begin
        n.rdat = lk.rdata;
        n.st = S_DONE;
      end
      S_PL1: n.st = S_PL2;
      S_PL2: begin
        if (!lk.rdata[ffp_pkg::SKIP_BIT]) begin
          n.pend = 1'b0;
          n.la = avs_address;
          n.st = S_ACC;
        end else begin
          n.st = S_PL1;
        end
      end
      S_DONE: n.st = S_IDLE;
      default: n.st = S_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.need_rd <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs
  assign lk.cs = (q.st == S_DUM) | (q.st == S_ACC) | (q.st == S_PL1);
  assign lk.we = q.lwe;
  assign lk.addr = q.la;
  assign lk.wdata = q.lwd;
  assign avs_readdata = q.rdat;
  assign avs_waitrequest = (q.st != S_DONE);
endmodule : ffp_host

// File: core/ffp_if.sv
`timescale 1ns/1ps
// Register link between controller and device
interface ffp_if;
  logic cs;
  logic we;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport dev (input cs, input we, input addr, input wdata, output rdata);
  modport host (output cs, output we, output addr, output wdata,
                input rdata);
endinterface : ffp_if

// File: core/ffp_pkg.sv
package ffp_pkg;
  //////////////////////////////////////////////////////////////////////////////
  // Link register offsets
  localparam logic [7:0] RX_DATA_OFS = 8'h00;
  localparam logic [7:0] TX_DATA_OFS = 8'h20;
  localparam logic [7:0] TX_LAST_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h68;
  localparam logic [7:0] LEVEL_OFS = 8'h6c;
  localparam logic [7:0] HW_SETUP_OFS = 8'h74;
  localparam logic [7:0] RX_PATH_OFS = 8'h78;
  // Controller's own registers
  localparam logic [7:0] HOST_CTRL_OFS = 8'hf0;
  localparam logic [7:0] HOST_STAT_OFS = 8'hf4;
  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SOFT_RST_BIT = 0;
  localparam int TO_BIT = 1;
  localparam int STRAP_BIT = 2;
  localparam int KB_LSB = 16;
  localparam int SKIP_BIT = 31;
  localparam int DROP_LSB = 16;
  localparam int TXFREE_LSB = 16;
  // Values after reset and legal range of the partition size
  localparam logic [3:0] KB_RST = 4'h5;
  localparam logic [3:0] KB_MIN = 4'h2;
  localparam logic [3:0] KB_MAX = 4'he;
  //////////////////////////////////////////////////////////////////////////////
  // Sizes in 32-bit words
  localparam logic [12:0] MEM_WORDS = 13'h1000;
  localparam logic [11:0] TXS_WORDS = 12'h080;
  localparam logic [11:0] RXD_GAP = 12'h004;
  localparam logic [9:0] STG_TX_WORDS = 10'h200;
  localparam logic [5:0] STG_RX_WORDS = 6'h20;
  // Soft reset time-out
  localparam int CLK_NS = 10;
  localparam int SOFT_TMO_NS = 10000;
  localparam int SOFT_TMO_CYC = SOFT_TMO_NS / CLK_NS;
  //////////////////////////////////////////////////////////////////////////////
  // Partition code held to its legal range for sizing
  function automatic logic [3:0] f_kb(input logic [3:0] kb);
    if (kb < KB_MIN) return KB_MIN;
    if (kb > KB_MAX) return KB_MAX;
    return kb;
  endfunction : f_kb

  // Words in the transmit data FIFO
  function automatic logic [11:0] f_txd_words(input logic [3:0] kb);
    return {f_kb(kb), 8'h00} - TXS_WORDS;
  endfunction : f_txd_words

  // Words in the receive data FIFO
  function automatic logic [11:0] f_rxd_words(input logic [3:0] kb);
    logic [12:0] rx;
    rx = MEM_WORDS - {1'b0, f_kb(kb), 8'h00};
    return 12'(rx - (rx >> 4));
  endfunction : f_rxd_words

  // Pointer step with wrap at the region size
  function automatic logic [11:0] f_inc(input logic [11:0] p,
                                        input logic [11:0] sz);
    return (p == sz - 12'h001) ? 12'h000 : p + 12'h001;
  endfunction : f_inc
endpackage : ffp_pkg

// File: testbench/ffp_props.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Link checker: watches the register link between the two ends
module ffp_props #(
  parameter logic [15:0] TMO_CYC = 16'h03e8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link signals
  input wire logic cs,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata
);
  logic rd_q;
  logic kbv_q;
  logic sr_q;
  logic [3:0] kb_q;
  logic [15:0] cnt_q;
  wire wr_hw = cs && we && addr == ffp_pkg::HW_SETUP_OFS;
  wire sr_go = wr_hw && wdata[0];

  // Track first read, written partition and soft reset age
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q <= 1'b0;
      kbv_q <= 1'b0;
      sr_q <= 1'b0;
      kb_q <= 4'h0;
      cnt_q <= 16'hffff;
    end else begin
      if (cs && !we) rd_q <= 1'b1;
      if (wr_hw) kbv_q <= !wdata[0];
      if (wr_hw) kb_q <= wdata[19:16];
      if (sr_go) sr_q <= 1'b1;
      if (sr_go) cnt_q <= 16'h0000;
      else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Read request at a given offset
  sequence s_rd(logic [7:0] a);
    cs && !we && addr == a;
  endsequence

  property p_read_first;
    cs && we |-> rd_q;
  endproperty
  a_read_first: assert property (p_read_first)
    else $error("link write before any read");
  property p_kb_legal;
    wr_hw |-> wdata[19:16] >= 4'h2 && wdata[19:16] <= 4'he;
  endproperty
  a_kb_legal: assert property (p_kb_legal)
    else $error("partition code out of range on link");
  property p_kb_read;
    s_rd(ffp_pkg::HW_SETUP_OFS) ##0 kbv_q |=> rdata[19:16] == kb_q;
  endproperty
  a_kb_read: assert property (p_kb_read)
    else $error("partition field differs from written value");
  property p_setup_rsvd;
    s_rd(ffp_pkg::HW_SETUP_OFS) |=> rdata[31:20] == 12'h000
      && rdata[15:3] == 13'h0000;
  endproperty
  a_setup_rsvd: assert property (p_setup_rsvd)
    else $error("setup register reserved bits set");
  property p_self_clear;
    s_rd(ffp_pkg::HW_SETUP_OFS) ##1 rdata[0] |-> cnt_q <= TMO_CYC + 16'h0020;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("soft reset bit stays set too long");
  property p_tmo_cause;
    s_rd(ffp_pkg::HW_SETUP_OFS) ##1 rdata[1] |-> sr_q && cnt_q >= TMO_CYC;
  endproperty
  a_tmo_cause: assert property (p_tmo_cause)
    else $error("time-out flag without expired soft reset");
  property p_skip_rsvd;
    s_rd(ffp_pkg::RX_PATH_OFS) |=> rdata[30:0] == 31'h00000000;
  endproperty
  a_skip_rsvd: assert property (p_skip_rsvd)
    else $error("receive path reserved bits set");
  property p_level_rsvd;
    s_rd(ffp_pkg::LEVEL_OFS) |=> rdata[15:12] == 4'h0 && rdata[31:28] == 4'h0
      && rdata[27:16] <= 12'hd80;
  endproperty
  a_level_rsvd: assert property (p_level_rsvd)
    else $error("level register out of bounds");
endmodule : ffp_props

// File: testbench/tb_fifo_partition_soft_reset.sv
`timescale 1ns/1ps
module tb_fifo_partition_soft_reset;
  logic mclk, sys_rst, strap, phy_run, phy_rdy, tx_rdy, rx_v, rx_l;
  logic a_rd, a_wr, a_wait, tx_v, tx_l, csr_rst;
  logic [7:0] a_addr;
  logic [31:0] a_wd, a_rdq, rx_d, tx_d, q, d;
  logic [32:0] txq[$];
  logic [32:0] gotq[$];
  logic [31:0] rxq[$];
  integer seed, error_cnt, tests_run, cyc, pulses;

  ffp_if lk();
  ffp_host i_ffp_host (.mclk(mclk), .sys_rst(sys_rst), .avs_address(a_addr),
    .avs_read(a_rd), .avs_write(a_wr), .avs_writedata(a_wd),
    .avs_readdata(a_rdq), .avs_waitrequest(a_wait), .phy_ready(phy_rdy),
    .lk(lk));
  ffp_device #(.TMO_CYC(16'h0008)) i_ffp_device (.mclk(mclk),
    .sys_rst(sys_rst), .lk(lk), .bus_width_strap(strap),
    .phy_clk_run(phy_run), .mac_tx_valid(tx_v), .mac_tx_data(tx_d),
    .mac_tx_last(tx_l), .mac_tx_ready(tx_rdy), .mac_rx_valid(rx_v),
    .mac_rx_data(rx_d), .mac_rx_last(rx_l), .mac_csr_reset(csr_rst));
  ffp_props #(.TMO_CYC(16'h0008)) u_props (.mclk(mclk), .sys_rst(sys_rst),
    .cs(lk.cs), .we(lk.we), .addr(lk.addr), .wdata(lk.wdata),
    .rdata(lk.rdata));

  // Expected level word from partition code and used count
  function automatic logic [31:0] lvl(input logic [3:0] k,
                                      input logic [11:0] u);
    return {4'h0, {k, 8'h00} - 12'h080, 4'h0, u};
  endfunction : lvl
  // Receive data words for a partition code
  function automatic logic [11:0] rxw(input logic [3:0] k);
    logic [12:0] r;
    r = 13'h1000 - {1'b0, k, 8'h00};
    return 12'(r - (r >> 4));
  endfunction : rxw

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task print_verdict;
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // One Avalon transfer, held until waitrequest is low
  task av(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    a_addr <= a;
    a_wr <= w;
    a_rd <= !w;
    a_wd <= v;
    @(posedge mclk);
    while (a_wait !== 1'b0) @(posedge mclk);
    q = a_rdq;
    a_rd <= 1'b0;
    a_wr <= 1'b0;
  endtask : av
  task rd(input logic [7:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk({1'b0, q}, {1'b0, e});
  endtask : rd
  // Read until the given bit clears
  task poll(input logic [7:0] a, input int b);
    for (int i = 0; i < 60; i++) begin
      av(1'b0, a, 32'h0);
      if (q[b] === 1'b0) break;
    end
  endtask : poll
  // MAC receive frame, one word per cycle
  task rx_frame(input int n, input bit keep);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      d = $random(seed);
      if (keep) rxq.push_back(d);
      rx_v <= 1'b1;
      rx_d <= d;
      rx_l <= (i == n - 1);
    end
    @(posedge mclk);
    rx_v <= 1'b0;
  endtask : rx_frame

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // MAC stalls, transmit capture, pulse count and time limit
  always @(posedge mclk) begin
    tx_rdy <= 1'($random(seed));
    if (tx_v === 1'b1 && tx_rdy === 1'b1) gotq.push_back({tx_l, tx_d});
    if (csr_rst === 1'b1) pulses++;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end

  // Main sequence
  initial begin
    {seed, error_cnt, tests_run, cyc, pulses} = {32'hddc4, 128'h0};
    {sys_rst, strap, phy_run, phy_rdy} = 4'hf;
    {tx_rdy, rx_v, rx_l, a_rd, a_wr, a_addr, a_wd, rx_d} = 77'h0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h74, 32'h0005_0004);
    strap <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(8'h74, 32'h0005_0000);
    rd(8'h6c, lvl(4'h5, 12'h000));
    // Refused while MAC runs, then out-of-range code
    av(1'b1, 8'h74, 32'h0006_0000);
    rd(8'hf4, 32'h1);
    rd(8'h74, 32'h0005_0000);
    av(1'b1, 8'hf4, 32'h1);
    av(1'b1, 8'hf0, 32'h1);
    av(1'b1, 8'h74, 32'h000f_0000);
    rd(8'hf4, 32'h1);
    av(1'b1, 8'hf4, 32'h1);
    av(1'b0, 8'h00, 32'h0);
    rd(8'h68, 32'h2);
    // Every legal partition code
    for (int k = 2; k < 15; k++) begin
      av(1'b1, 8'h74, {12'h000, 4'(k), 16'h0000});
      rd(8'h74, {12'h000, 4'(k), 16'h0000});
      rd(8'h6c, lvl(4'(k), 12'h000));
    end
    // Transmit words through staging with MAC stalls
    for (int i = 0; i < 5; i++) begin
      d = $random(seed);
      txq.push_back({i == 4, d});
      av(1'b1, (i == 4) ? 8'h24 : 8'h20, d);
    end
    for (int i = 0; i < 200 && gotq.size() < 5; i++) @(posedge mclk);
    while (txq.size() > 0) begin
      chk(gotq.size() > 0 ? gotq.pop_front() : 33'h0, txq.pop_front());
    end
    // Overrun at smallest receive share, second frame dropped too
    rx_frame(600, 1'b0);
    rx_frame(4, 1'b0);
    rd(8'h6c, lvl(4'he, rxw(4'he) - 12'h004));
    rd(8'h68, 32'h0002_0002);
    // Soft reset with PHY clocks stopped times out
    phy_run <= 1'b0;
    repeat (4) @(posedge mclk);
    av(1'b1, 8'h74, 32'h0005_0001);
    poll(8'h74, 0);
    chk({1'b0, q}, 33'h0_0005_0002);
    chk(33'(pulses), 33'h0);
    // Soft reset refused while the PHY is not awake
    phy_rdy <= 1'b0;
    repeat (3) @(posedge mclk);
    av(1'b1, 8'h74, 32'h0005_0001);
    rd(8'hf4, 32'h1);
    rd(8'h74, 32'h0005_0002);
    av(1'b1, 8'hf4, 32'h1);
    // Clocks restored, retry succeeds
    phy_run <= 1'b1;
    phy_rdy <= 1'b1;
    repeat (4) @(posedge mclk);
    av(1'b1, 8'h74, 32'h0005_0001);
    poll(8'h74, 0);
    chk({1'b0, q}, 33'h0_0005_0000);
    chk(33'(pulses), 33'h1);
    rd(8'h68, 32'h0);
    rd(8'h6c, lvl(4'h5, 12'h000));
    // Skip first frame, then read the second
    rx_frame(3, 1'b1);
    rx_frame(2, 1'b1);
    av(1'b1, 8'h78, 32'h8000_0000);
    poll(8'h78, 31);
    repeat (3) void'(rxq.pop_front());
    rd(8'h00, rxq.pop_front());
    rd(8'h6c, lvl(4'h5, 12'h001));
    rd(8'h00, rxq.pop_front());
    print_verdict;
  end
endmodule : tb_fifo_partition_soft_reset
